// *** alu64_pkg.sv ***
/*
 * Shared constants and types for the doubleword add / leading-ones datapath:
 * instruction field positions, fixed encodings, widths and the state and
 * operation enumerations.
 * Assumes a 32-bit instruction word with the usual six-bit major opcode on top.
 */
package alu64_pkg;

  // data path and register file geometry
  localparam int XLEN = 64;
  localparam int SEL_W = 5;
  localparam int NREGS = 32;
  localparam int IMM_W = 16;
  localparam int CNT_W = 7;
  localparam int INSTR_W = 32;

  //////////////////////////////////////////////////////////////////////////////
  // instruction field positions
  localparam int OP_HI = 31;
  localparam int OP_LO = 26;
  localparam int SRCA_HI = 25;
  localparam int SRCA_LO = 21;
  localparam int SRCB_HI = 20;
  localparam int SRCB_LO = 16;
  localparam int DEST_HI = 15;
  localparam int DEST_LO = 11;
  localparam int SHF_HI = 10;
  localparam int SHF_LO = 6;
  localparam int FN_HI = 5;
  localparam int FN_LO = 0;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 0;

  //////////////////////////////////////////////////////////////////////////////
  // fixed encodings of the register-register adds
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [5:0] FN_ADD_TRAP = 6'h2c;
  localparam logic [5:0] FN_ADD_NONTRAP = 6'h2d;
  localparam logic [4:0] SHF_ZERO = 5'h00;
  localparam logic [SEL_W-1:0] SEL_ZERO = 5'h00;

  // result of a leading-ones count over an all-ones source
  localparam logic [CNT_W-1:0] ALL_ONES_COUNT = 7'h40;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic {
    IDLE,
    EXEC
  } fsm_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADD_TRAP,
    OP_ADD_NONTRAP,
    OP_ADDI_TRAP,
    OP_ADDI_NONTRAP,
    OP_CLO
  } op_t;

endpackage

// *** gpr_file.sv ***
/*
 * General register file: 32 words of 64 bits, two read ports whose data come
 * out of registers one cycle after the select, one write port.
 * Assumes the caller never needs read-during-write bypass; entry zero reads 0.
 */
`timescale 1ns/1ps
module gpr_file
  import alu64_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // read ports
  input wire logic [SEL_W-1:0] rd_sel_a,
  input wire logic [SEL_W-1:0] rd_sel_b,
  output logic [XLEN-1:0] rd_data_a,
  output logic [XLEN-1:0] rd_data_b,
  // write port
  input wire logic wr_en,
  input wire logic [SEL_W-1:0] wr_sel,
  input wire logic [XLEN-1:0] wr_data
);

  logic [XLEN-1:0] mem [NREGS];
  logic [XLEN-1:0] next_rd_data_a;
  logic [XLEN-1:0] next_rd_data_b;

  // entry zero is hardwired, so its storage is never consulted
  always_comb begin
    next_rd_data_a = (rd_sel_a == SEL_ZERO) ? '0 : mem[rd_sel_a];
    next_rd_data_b = (rd_sel_b == SEL_ZERO) ? '0 : mem[rd_sel_b];
  end

  // storage is data only and carries no reset
  always_ff @(posedge clk) begin
    if (wr_en && (wr_sel != SEL_ZERO)) begin
      mem[wr_sel] <= wr_data;
    end
  end

  // registered read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else begin
      rd_data_a <= next_rd_data_a;
      rd_data_b <= next_rd_data_b;
    end
  end

endmodule // gpr_file

// *** dword_add_clo_alu.sv ***
/*
 * Integer slice: doubleword adds (trapping and wrapping, register and
 * immediate forms) and a leading-ones count, with the register file inside.
 * Assumes the decoder holds INSTR_VALID and INSTR until READY is seen high,
 * and that RELEASE6 and OPS64_EN are quasi-static levels.
 */
`timescale 1ns/1ps

// Function
// - Trapping register add: opcode 000000, bits 10..6 zero, function 101100.
// - Trapping register add writes the 64-bit sum to dest when no overflow.
// - Signed overflow on a trapping add suppresses the write and signals overflow.
// - Trapping immediate add: source A plus sign-extended immediate into source B reg.
// - On the newer release the trapping immediate opcode is not an add.
// - Wrapping immediate add writes the modulo sum into the source B reg.
// - Wrapping register add: opcode 000000, function 101101, modulo sum to dest.
// - Wrapping adds never signal overflow and always write while OPS64_EN is high.
// - Trapping adds also have a reserved-instruction exception output.
// - Leading-ones count from the top bit; all ones gives 64.
// - Newer release: count with nonzero source B field is a reserved instruction.
module dword_add_clo_alu
  import alu64_pkg::*;
#(
  parameter logic [5:0] OPC_ADDI_TRAP = 6'h18,
  parameter logic [5:0] OPC_ADDI_NONTRAP = 6'h19,
  parameter logic [5:0] OPC_CLO_OLD = 6'h1c,
  parameter logic [5:0] FN_CLO_OLD = 6'h25,
  parameter logic [5:0] FN_CLO_NEW = 6'h13,
  parameter logic [4:0] SHF_CLO_NEW = 5'h01
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // configuration levels
  input wire logic RELEASE6,
  input wire logic OPS64_EN,
  // instruction issue
  input wire logic INSTR_VALID,
  input wire logic [INSTR_W-1:0] INSTR,
  output logic READY,
  // register preload from outside, idle cycles only
  input wire logic EXT_WE,
  input wire logic [SEL_W-1:0] EXT_SEL,
  input wire logic [XLEN-1:0] EXT_DATA,
  // completion
  output logic DONE,
  output logic RESULT_WE,
  output logic [SEL_W-1:0] RESULT_SEL,
  output logic [XLEN-1:0] RESULT,
  output logic OVF_EXC,
  output logic RI_EXC,
  output logic UNSUP
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [XLEN-1:0] sext_imm(input logic [IMM_W-1:0] imm);
    return {{(XLEN-IMM_W){imm[IMM_W-1]}}, imm};
  endfunction

  // 65-bit sum of sign-extended addends
  function automatic logic [XLEN:0] wide_add(input logic [XLEN-1:0] a,
                                             input logic [XLEN-1:0] b);
    return {a[XLEN-1], a} + {b[XLEN-1], b};
  endfunction

  function automatic logic [CNT_W-1:0] lead_ones(input logic [XLEN-1:0] v);
    logic [CNT_W-1:0] n;
    logic stop;
    n = '0;
    stop = 1'b0;
    for (int i = XLEN - 1; i >= 0; i--) begin
      if (!stop) begin
        if (v[i]) begin
          n = n + 7'h01;
        end else begin
          stop = 1'b1;
        end
      end
    end
    return n;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // decode of the word on INSTR
  logic [5:0] d_opc;
  logic [5:0] d_fn;
  logic [4:0] d_shf;
  logic [SEL_W-1:0] d_srcb;
  logic d_clo_new;
  logic d_clo_old;
  op_t d_op;
  logic d_ri;

  always_comb begin
    d_opc = INSTR[OP_HI:OP_LO];
    d_fn = INSTR[FN_HI:FN_LO];
    d_shf = INSTR[SHF_HI:SHF_LO];
    d_srcb = INSTR[SRCB_HI:SRCB_LO];
    d_clo_new = (d_opc == OPC_SPECIAL) && (d_fn == FN_CLO_NEW) && (d_shf == SHF_CLO_NEW);
    d_clo_old = (d_opc == OPC_CLO_OLD) && (d_fn == FN_CLO_OLD) && (d_shf == SHF_ZERO);
    d_op = OP_NONE;
    if ((d_opc == OPC_SPECIAL) && (d_shf == SHF_ZERO) && (d_fn == FN_ADD_TRAP)) begin
      d_op = OP_ADD_TRAP;
    end else if ((d_opc == OPC_SPECIAL) && (d_shf == SHF_ZERO)
                 && (d_fn == FN_ADD_NONTRAP)) begin
      d_op = OP_ADD_NONTRAP;
    end else if ((d_opc == OPC_ADDI_TRAP) && !RELEASE6) begin
      d_op = OP_ADDI_TRAP;
    end else if (d_opc == OPC_ADDI_NONTRAP) begin
      d_op = OP_ADDI_NONTRAP;
    end else if (RELEASE6 ? d_clo_new : d_clo_old) begin
      d_op = OP_CLO;
    end
    // 64-bit ops off, or the new count form with a leftover source B field
    d_ri = (d_op != OP_NONE) && !OPS64_EN;
    if ((d_op == OP_CLO) && RELEASE6 && (d_srcb != SEL_ZERO)) begin
      d_ri = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control state: one instruction in flight
  fsm_t state;
  fsm_t next_state;
  op_t op;
  op_t next_op;
  logic ri;
  logic next_ri;
  logic [INSTR_W-1:0] instr;
  logic [INSTR_W-1:0] next_instr;
  logic accept;

  assign READY = (state == IDLE);
  assign accept = INSTR_VALID && READY;

  always_comb begin
    next_state = state;
    next_op = op;
    next_ri = ri;
    next_instr = instr;
    case (state)
      IDLE: begin
        if (INSTR_VALID) begin
          next_state = EXEC;
          next_op = d_op;
          next_ri = d_ri;
          next_instr = INSTR;
        end
      end
      EXEC: begin
        next_state = IDLE;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= IDLE;
      op <= OP_NONE;
      ri <= 1'b0;
      instr <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      ri <= next_ri;
      instr <= next_instr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register file; reads issued straight from INSTR so data land in EXEC
  logic [XLEN-1:0] opnd_a;
  logic [XLEN-1:0] opnd_b;
  logic gpr_we;
  logic [SEL_W-1:0] gpr_wsel;
  logic [XLEN-1:0] gpr_wdata;
  logic ex_we;
  logic [SEL_W-1:0] ex_sel;
  logic [XLEN-1:0] ex_val;

  // preload only while idle, so it can never collide with a result write
  always_comb begin
    gpr_we = (state == EXEC) ? ex_we : EXT_WE;
    gpr_wsel = (state == EXEC) ? ex_sel : EXT_SEL;
    gpr_wdata = (state == EXEC) ? ex_val : EXT_DATA;
  end

  gpr_file u_gpr (
    .clk(CLK),
    .rst_n(RST_N),
    .rd_sel_a(INSTR[SRCA_HI:SRCA_LO]),
    .rd_sel_b(INSTR[SRCB_HI:SRCB_LO]),
    .rd_data_a(opnd_a),
    .rd_data_b(opnd_b),
    .wr_en(gpr_we),
    .wr_sel(gpr_wsel),
    .wr_data(gpr_wdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // execute
  logic [XLEN-1:0] addend;
  logic [XLEN:0] wsum;
  logic ovf;
  logic ex_ovf;

  always_comb begin
    addend = ((op == OP_ADDI_TRAP) || (op == OP_ADDI_NONTRAP))
             ? sext_imm(instr[IMM_HI:IMM_LO]) : opnd_b;
    wsum = wide_add(opnd_a, addend);
    ovf = wsum[XLEN] ^ wsum[XLEN-1];
    ex_ovf = 1'b0;
    ex_we = 1'b0;
    ex_sel = instr[DEST_HI:DEST_LO];
    ex_val = wsum[XLEN-1:0];
    if ((state == EXEC) && !ri) begin
      case (op)
        OP_ADD_TRAP, OP_ADDI_TRAP: begin
          ex_ovf = ovf;
          ex_we = !ovf;
        end
        OP_ADD_NONTRAP, OP_ADDI_NONTRAP: begin
          ex_we = 1'b1;
        end
        OP_CLO: begin
          ex_we = 1'b1;
          ex_val = {{(XLEN-CNT_W){1'b0}}, lead_ones(opnd_a)};
        end
        default: begin
          ex_we = 1'b0;
        end
      endcase
    end
    // immediate forms target the source B register
    if ((op == OP_ADDI_TRAP) || (op == OP_ADDI_NONTRAP)) begin
      ex_sel = instr[SRCB_HI:SRCB_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // completion outputs, one-cycle report after EXEC
  logic next_done;
  logic next_unsup;

  always_comb begin
    next_done = (state == EXEC);
    next_unsup = (state == EXEC) && (op == OP_NONE);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DONE <= 1'b0;
      RESULT_WE <= 1'b0;
      RESULT_SEL <= '0;
      RESULT <= '0;
      OVF_EXC <= 1'b0;
      RI_EXC <= 1'b0;
      UNSUP <= 1'b0;
    end else begin
      DONE <= next_done;
      RESULT_WE <= ex_we;
      RESULT_SEL <= ex_sel;
      RESULT <= ex_val;
      OVF_EXC <= ex_ovf;
      RI_EXC <= next_done && ri;
      UNSUP <= next_unsup;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  logic trap_op;
  logic ovf_ref;
  assign trap_op = (op == OP_ADD_TRAP) || (op == OP_ADDI_TRAP);
  assign ovf_ref = (opnd_a[XLEN-1] == addend[XLEN-1])
                   && (wsum[XLEN-1] != opnd_a[XLEN-1]);

  decode_add_a: assert property (
    accept && (d_opc == OPC_SPECIAL) && (d_fn == FN_ADD_TRAP) && (d_shf == SHF_ZERO)
    |=> (op == OP_ADD_TRAP))
    else $error("trapping register add not decoded");
  add_sum_a: assert property (
    (state == EXEC) && (op == OP_ADD_TRAP) && !ri && !ovf_ref
    |=> RESULT_WE && (RESULT == $past(opnd_a) + $past(opnd_b))
        && (RESULT_SEL == $past(instr[DEST_HI:DEST_LO])))
    else $error("trapping add result wrong");
  ovf_suppress_a: assert property (
    (state == EXEC) && trap_op && !ri && ovf_ref |=> OVF_EXC && !RESULT_WE && DONE)
    else $error("overflow did not suppress the write");
  ovf_method_a: assert property (
    (state == EXEC) |-> (ovf == ovf_ref))
    else $error("overflow detect disagrees");
  imm_trap_a: assert property (
    (state == EXEC) && (op == OP_ADDI_TRAP) && !ri && !ovf_ref
    |=> RESULT_WE && (RESULT_SEL == $past(instr[SRCB_HI:SRCB_LO]))
        && (RESULT == $past(opnd_a) + $past(sext_imm(instr[IMM_HI:IMM_LO]))))
    else $error("trapping immediate add wrong");
  r6_reuse_a: assert property (
    accept && RELEASE6 && (d_opc == OPC_ADDI_TRAP) |=> (op != OP_ADDI_TRAP) ##1 !OVF_EXC)
    else $error("removed opcode decoded as add");
  imm_wrap_a: assert property (
    (state == EXEC) && (op == OP_ADDI_NONTRAP) && !ri
    |=> RESULT_WE && (RESULT_SEL == $past(instr[SRCB_HI:SRCB_LO]))
        && (RESULT == $past(opnd_a) + $past(sext_imm(instr[IMM_HI:IMM_LO]))))
    else $error("wrapping immediate add wrong");
  decode_wrap_a: assert property (
    accept && (d_opc == OPC_SPECIAL) && (d_fn == FN_ADD_NONTRAP) && (d_shf == SHF_ZERO)
    |=> (op == OP_ADD_NONTRAP))
    else $error("wrapping register add not decoded");
  no_ovf_a: assert property (
    (state == EXEC) && !ri && ((op == OP_ADD_NONTRAP) || (op == OP_ADDI_NONTRAP))
    |=> !OVF_EXC && RESULT_WE)
    else $error("wrapping add trapped or skipped write");

  ri_out_a: assert property (
    accept && d_ri |-> ##2 (RI_EXC && DONE && !RESULT_WE && !OVF_EXC))
    else $error("reserved instruction not reported");

  clo_count_a: assert property (
    (state == EXEC) && (op == OP_CLO) && !ri && (&opnd_a)
    |=> RESULT_WE && (RESULT[CNT_W-1:0] == ALL_ONES_COUNT))
    else $error("all-ones count is not 64");

  r6_clo_ri_a: assert property (
    accept && RELEASE6 && d_clo_new && (d_srcb != SEL_ZERO) |-> ##2 RI_EXC)
    else $error("new count form with source B set not refused");

endmodule // dword_add_clo_alu

// *** instr_source.sv ***
/*
 * Model of the decoder and issue side that feeds the datapath slice.
 * Assumes the unit answers within a few cycles and idles with READY high.
 */
`timescale 1ns/1ps
module instr_source
  import alu64_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // unit status
  input wire logic ready,
  input wire logic done,
  input wire logic result_we,
  input wire logic [SEL_W-1:0] result_sel,
  input wire logic [XLEN-1:0] result,
  input wire logic ovf_exc,
  input wire logic ri_exc,
  input wire logic unsup,
  // issue and preload
  output logic instr_valid,
  output logic [INSTR_W-1:0] instr,
  output logic ext_we,
  output logic [SEL_W-1:0] ext_sel,
  output logic [XLEN-1:0] ext_data
);
  logic got_done;
  logic got_again;
  logic got_we;
  logic [SEL_W-1:0] got_sel;
  logic [XLEN-1:0] got_res;
  logic [2:0] got_exc;
  logic got_busy;

  // quiet lines from time zero
  initial begin
    instr_valid = 1'b0;
    instr = '0;
    ext_we = 1'b0;
    ext_sel = '0;
    ext_data = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // old count form: software repeats the dest number in the source b field
  function automatic logic [INSTR_W-1:0] count_word_old(input logic [4:0] a, d);
    return {6'h1c, a, d, d, 5'h00, 6'h25};
  endfunction

  // one preload write; released lines show inverted data, not stale values
  task automatic preload(input logic [SEL_W-1:0] sel, input logic [XLEN-1:0] data);
    @(posedge clk);
    #1;
    ext_we = 1'b1;
    ext_sel = sel;
    ext_data = data;
    @(posedge clk);
    #1;
    ext_we = 1'b0;
    ext_sel = ~sel;
    ext_data = ~data;
  endtask

  // request held until taken, then the completion cycle is captured
  task automatic issue(input logic [INSTR_W-1:0] word);
    int n;
    logic taken;
    got_done = 1'b0;
    got_again = 1'b0;
    @(posedge clk);
    #1;
    instr_valid = 1'b1;
    instr = word;
    n = 0;
    taken = 1'b0;
    // look at ready away from the edge, so a stalled retry does not race it
    while (!taken && n < 8) begin
      taken = (ready === 1'b1);
      @(posedge clk);
      if (!taken) begin
        #1;
      end
      n++;
    end
    #1;
    got_busy = ready;
    instr_valid = 1'b0;
    instr = ~word;
    n = 0;
    while (got_done !== 1'b1 && n < 6) begin
      if (done === 1'b1) begin
        got_done = 1'b1;
        got_we = result_we;
        got_sel = result_sel;
        got_res = result;
        got_exc = {ovf_exc, ri_exc, unsup};
        @(posedge clk);
        #1;
        got_again = done;
      end else begin
        @(posedge clk);
        #1;
      end
      n++;
    end
  endtask
endmodule // instr_source

// *** tb.sv ***
/*
 * Self-checking bench for the doubleword add and leading-ones slice.
 * Assumes the instr_source model drives the issue and preload ports.
 */
`timescale 1ns/1ps
module tb;
  import alu64_pkg::*;
  logic CLK;
  logic RST_N;
  logic RELEASE6;
  logic OPS64_EN;
  logic INSTR_VALID;
  logic [INSTR_W-1:0] INSTR;
  logic READY;
  logic EXT_WE;
  logic [SEL_W-1:0] EXT_SEL;
  logic [XLEN-1:0] EXT_DATA;
  logic DONE;
  logic RESULT_WE;
  logic [SEL_W-1:0] RESULT_SEL;
  logic [XLEN-1:0] RESULT;
  logic OVF_EXC;
  logic RI_EXC;
  logic UNSUP;
  int fails = 0;
  int checks = 0;

  dword_add_clo_alu dut (.CLK(CLK), .RST_N(RST_N), .RELEASE6(RELEASE6),
    .OPS64_EN(OPS64_EN), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .READY(READY),
    .EXT_WE(EXT_WE), .EXT_SEL(EXT_SEL), .EXT_DATA(EXT_DATA), .DONE(DONE),
    .RESULT_WE(RESULT_WE), .RESULT_SEL(RESULT_SEL), .RESULT(RESULT),
    .OVF_EXC(OVF_EXC), .RI_EXC(RI_EXC), .UNSUP(UNSUP));

  instr_source src (.clk(CLK), .rst_n(RST_N), .ready(READY), .done(DONE),
    .result_we(RESULT_WE), .result_sel(RESULT_SEL), .result(RESULT),
    .ovf_exc(OVF_EXC), .ri_exc(RI_EXC), .unsup(UNSUP), .instr_valid(INSTR_VALID),
    .instr(INSTR), .ext_we(EXT_WE), .ext_sel(EXT_SEL), .ext_data(EXT_DATA));

  // 125 MHz core clock
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] seen, exp, input string msg);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [31:0] rw(input logic [5:0] op, input logic [4:0] a, b, d, sh,
                                     input logic [5:0] fn);
    return {op, a, b, d, sh, fn};
  endfunction

  function automatic logic [31:0] iw(input logic [5:0] op, input logic [4:0] a, b,
                                     input logic [15:0] imm);
    return {op, a, b, imm};
  endfunction

  // one instruction; a lost completion ends the run at once
  task automatic run(input logic [31:0] w, input logic we, input logic [4:0] sel,
                     input logic [63:0] res, input logic [2:0] exc);
    src.issue(w);
    chk(src.got_done, 1'b1, "completion");
    if (src.got_done !== 1'b1)
      summarize();
    chk(src.got_again, 1'b0, "done width");
    chk(src.got_busy, 1'b0, "ready in exec");
    chk(src.got_exc, exc, "ovf ri unsup");
    chk(src.got_we, we, "write flag");
    if (we) begin
      chk(src.got_sel, sel, "dest number");
      chk(src.got_res, res, "result");
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({READY, DONE, RESULT_WE, OVF_EXC, RI_EXC, UNSUP}, 6'h20, "idle outputs");
    $display("test reset done");
  endtask

  task automatic t_regadd();
    run(rw(6'h00, 1, 2, 3, 0, FN_ADD_TRAP), 1, 3, 64'hc, 0);
    run(rw(6'h00, 4, 5, 3, 0, FN_ADD_TRAP), 0, 0, 0, 3'b100);
    run(rw(6'h00, 7, 8, 3, 0, FN_ADD_TRAP), 0, 0, 0, 3'b100);
    run(rw(6'h00, 3, 0, 6, 0, FN_ADD_NONTRAP), 1, 6, 64'hc, 0);
    run(rw(6'h00, 4, 5, 9, 0, FN_ADD_NONTRAP), 1, 9, 64'h8000_0000_0000_0000, 0);
    run(rw(6'h00, 1, 2, 9, 5'h01, FN_ADD_TRAP), 0, 0, 0, 3'b001);
    $display("test regadd done");
  endtask

  task automatic t_immadd();
    run(iw(6'h18, 1, 10, 16'hfffe), 1, 10, 64'h3, 0);
    run(iw(6'h18, 4, 10, 16'h0001), 0, 0, 0, 3'b100);
    run(iw(6'h18, 7, 10, 16'hffff), 0, 0, 0, 3'b100);
    run(iw(6'h19, 4, 11, 16'h0001), 1, 11, 64'h8000_0000_0000_0000, 0);
    run(iw(6'h19, 1, 11, 16'h8000), 1, 11, 64'hffff_ffff_ffff_8005, 0);
    $display("test immadd done");
  endtask

  task automatic t_count();
    logic [63:0] v [5] = '{64'hffff_ffff_ffff_ffff, 64'h0, 64'h8000_0000_0000_0000,
                           64'hfff0_0000_0000_0001, 64'hffff_ffff_ffff_fffe};
    logic [63:0] n [5] = '{64'd64, 64'd0, 64'd1, 64'd12, 64'd63};
    for (int i = 0; i < 5; i++) begin
      src.preload(12, v[i]);
      run(src.count_word_old(12, 13), 1, 13, n[i], 0);
    end
    $display("test count done");
  endtask

  task automatic t_release6();
    RELEASE6 = 1'b1;
    run(iw(6'h18, 1, 10, 16'h0001), 0, 0, 0, 3'b001);
    run(rw(6'h00, 12, 0, 13, 5'h01, 6'h13), 1, 13, 64'd63, 0);
    run(rw(6'h00, 12, 3, 13, 5'h01, 6'h13), 0, 0, 0, 3'b010);
    RELEASE6 = 1'b0;
    $display("test release6 done");
  endtask

  task automatic t_reserved();
    OPS64_EN = 1'b0;
    run(rw(6'h00, 1, 2, 3, 0, FN_ADD_TRAP), 0, 0, 0, 3'b010);
    run(iw(6'h18, 1, 10, 16'h0001), 0, 0, 0, 3'b010);
    OPS64_EN = 1'b1;
    $display("test reserved done");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    RST_N = 1'b0;
    RELEASE6 = 1'b0;
    OPS64_EN = 1'b1;
    repeat (6) @(posedge CLK);
    #1;
    t_reset();
    RST_N = 1'b1;
    src.preload(1, 64'h5);
    src.preload(2, 64'h7);
    src.preload(4, 64'h7fff_ffff_ffff_ffff);
    src.preload(5, 64'h1);
    src.preload(7, 64'h8000_0000_0000_0000);
    src.preload(8, 64'hffff_ffff_ffff_ffff);
    t_regadd();
    t_immadd();
    t_count();
    t_release6();
    t_reserved();
    summarize();
  end
endmodule // tb
